//--- common/risc14_pkg.sv
// Purpose: shared constants for the 14-bit instruction decoder
// Assumes: one instruction offered per sys_clk cycle
// Notes: opcode fields, special words, status layout, register offsets
package risc14_pkg;

   // ---------------------------------------------------------------
   // instruction classes and field positions
   // ---------------------------------------------------------------
   localparam logic [1:0] CLASS_BYTE = 2'h0;
   localparam logic [1:0] CLASS_BIT = 2'h1;
   localparam logic [1:0] CLASS_JUMP = 2'h2;
   localparam logic [1:0] CLASS_LIT = 2'h3;
   localparam int CLASS_HI = 13;
   localparam int OP_HI = 11;
   localparam int DEST_POS = 7;
   localparam int BIT_HI = 9;
   localparam int FILE_HI = 6;

   // ---------------------------------------------------------------
   // byte-oriented opcodes
   // ---------------------------------------------------------------
   localparam logic [3:0] OP_MISC = 4'h0;
   localparam logic [3:0] OP_CLEAR = 4'h1;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_DEC = 4'h3;
   localparam logic [3:0] OP_IOR = 4'h4;
   localparam logic [3:0] OP_AND = 4'h5;
   localparam logic [3:0] OP_XOR = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_MOVE = 4'h8;
   localparam logic [3:0] OP_COMP = 4'h9;
   localparam logic [3:0] OP_INC = 4'hA;
   localparam logic [3:0] OP_DECSKIP = 4'hB;
   localparam logic [3:0] OP_RRC = 4'hC;
   localparam logic [3:0] OP_RLC = 4'hD;
   localparam logic [3:0] OP_SWAP = 4'hE;
   localparam logic [3:0] OP_INCSKIP = 4'hF;

   // ---------------------------------------------------------------
   // literal opcodes and whole-word controls
   // ---------------------------------------------------------------
   localparam logic [3:0] OP_LIT_IOR = 4'h8;
   localparam logic [3:0] OP_LIT_AND = 4'h9;
   localparam logic [3:0] OP_LIT_XOR = 4'hA;
   localparam logic [13:0] WORD_RETURN = 14'h0008;
   localparam logic [13:0] WORD_INT_RETURN = 14'h0009;
   localparam logic [13:0] WORD_WDT_CLEAR = 14'h0064;
   localparam logic [13:0] WORD_SLEEP = 14'h0063;

   // ---------------------------------------------------------------
   // timer-zero file address (plain default)
   // ---------------------------------------------------------------
   localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;

   // ---------------------------------------------------------------
   // register port offsets and status layout
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ACC = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam int CTRL_PSA_POS = 0;
   localparam int ST_C_POS = 0;
   localparam int ST_DC_POS = 1;
   localparam int ST_Z_POS = 2;
   localparam int ST_POWERDOWN_POS = 3;
   localparam int ST_TO_POS = 4;
   localparam logic RST_TO = 1'b1;
   localparam logic RST_POWERDOWN = 1'b1;
   localparam logic RST_PSA = 1'b1;
   localparam logic [7:0] RST_ACC = 8'h00;

endpackage

//--- src/risc14_instruction_decoder.sv
// Purpose: decode and execute one 14-bit instruction word per cycle
// Assumes: file_rd_data/pin_rd_data reflect instr_word[6:0] in the same cycle
// Notes: results, writes and control pulses appear one cycle after acceptance
`timescale 1ns/1ps

module risc14_instruction_decoder
   import risc14_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic [7:0] file_rd_data,
   input wire logic [7:0] pin_rd_data,
   input wire logic file_is_io,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic instr_ready,
   output logic [6:0] file_addr,
   output logic file_wr_en,
   output logic [7:0] file_wr_data,
   output logic pc_load,
   output logic [10:0] pc_target,
   output logic stack_push,
   output logic stack_pop,
   output logic nop_cycle,
   output logic int_enable_set,
   output logic prescaler_clear,
   output logic watchdog_clear,
   output logic sleep_enter,
   output logic [7:0] acc_value,
   output logic [4:0] status_flags
);

   typedef enum logic {ST_EXEC = 1'b0, ST_FLUSH = 1'b1} phase_e;

   typedef struct packed {
      phase_e phase;
      logic [7:0] acc;
      logic carry;
      logic digit_carry_flag;
      logic zero;
      logic timeout_status_bit;
      logic powerdown_status_bit;
      logic psa_timer;
      logic [6:0] file_addr;
      logic file_wr_en;
      logic [7:0] file_wr_data;
      logic pc_load;
      logic [10:0] pc_target;
      logic push;
      logic pop;
      logic gie_set;
      logic psc_clr;
      logic wdt_clr;
      logic sleep;
      logic [7:0] rdata;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   // ---------------------------------------------------------------
   // adder shared by add and subtract forms
   // ---------------------------------------------------------------
   // returns {carry, digit carry, sum}
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      return {full[8], low[4], full[7:0]};
   endfunction

   // ---------------------------------------------------------------
   // decode and execute
   // ---------------------------------------------------------------
   logic [1:0] iclass;
   logic [3:0] op;
   logic dest;
   logic [2:0] bsel;
   logic [6:0] faddr;
   logic [7:0] lit;
   logic [7:0] src;
   logic [7:0] res;
   logic [9:0] sum;
   logic wr_res;
   logic upd_z;
   logic upd_c;
   logic upd_dc;
   logic new_c;
   logic skip;
   logic take;

   assign iclass = instr_word[CLASS_HI -: 2];
   assign op = instr_word[OP_HI -: 4];
   assign dest = instr_word[DEST_POS];
   assign bsel = instr_word[BIT_HI -: 3];
   assign faddr = instr_word[FILE_HI:0];
   assign lit = instr_word[7:0];
   assign take = instr_valid && (s_r.phase == ST_EXEC);

   // io ports give pin levels; else forward a write still in flight
   always_comb
   begin
      if (file_is_io)
      begin
         src = pin_rd_data;
      end
      else if (s_r.file_wr_en && (s_r.file_addr == faddr))
      begin
         src = s_r.file_wr_data;
      end
      else
      begin
         src = file_rd_data;
      end
   end

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.file_wr_en = 1'b0;
      s_nxt.pc_load = 1'b0;
      s_nxt.push = 1'b0;
      s_nxt.pop = 1'b0;
      s_nxt.gie_set = 1'b0;
      s_nxt.psc_clr = 1'b0;
      s_nxt.wdt_clr = 1'b0;
      s_nxt.sleep = 1'b0;
      s_nxt.rdata = 8'h00;
      s_nxt.phase = ST_EXEC;
      res = 8'h00;
      sum = 10'h000;
      wr_res = 1'b0;
      upd_z = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      new_c = s_r.carry;
      skip = 1'b0;

      if (take)
      begin
         unique case (iclass)
            CLASS_BYTE:
            begin
               wr_res = 1'b1;
               upd_z = 1'b1;
               unique case (op)
                  OP_MISC:
                  begin
                     wr_res = dest;
                     upd_z = 1'b0;
                     res = s_r.acc;
                     if (!dest)
                     begin
                        if (instr_word == WORD_RETURN)
                        begin
                           s_nxt.pop = 1'b1;
                           s_nxt.pc_load = 1'b1;
                        end
                        else if (instr_word == WORD_INT_RETURN)
                        begin
                           s_nxt.pop = 1'b1;
                           s_nxt.pc_load = 1'b1;
                           s_nxt.gie_set = 1'b1;
                        end
                        else if (instr_word == WORD_WDT_CLEAR)
                        begin
                           s_nxt.wdt_clr = 1'b1;
                           s_nxt.timeout_status_bit = 1'b1;
                           s_nxt.powerdown_status_bit = 1'b1;
                        end
                        else if (instr_word == WORD_SLEEP)
                        begin
                           s_nxt.sleep = 1'b1;
                           s_nxt.timeout_status_bit = 1'b1;
                           s_nxt.powerdown_status_bit = 1'b0;
                        end
                     end
                  end
                  OP_CLEAR:
                  begin
                     res = 8'h00;
                  end
                  OP_SUB:
                  begin
                     sum = add8(src, ~s_r.acc, 1'b1);
                     res = sum[7:0];
                     upd_c = 1'b1;
                     upd_dc = 1'b1;
                     new_c = sum[9];
                  end
                  OP_DEC:
                  begin
                     res = src - 8'h01;
                  end
                  OP_IOR:
                  begin
                     res = s_r.acc | src;
                  end
                  OP_AND:
                  begin
                     res = s_r.acc & src;
                  end
                  OP_XOR:
                  begin
                     res = s_r.acc ^ src;
                  end
                  OP_ADD:
                  begin
                     sum = add8(src, s_r.acc, 1'b0);
                     res = sum[7:0];
                     upd_c = 1'b1;
                     upd_dc = 1'b1;
                     new_c = sum[9];
                  end
                  OP_MOVE:
                  begin
                     res = src;
                  end
                  OP_COMP:
                  begin
                     res = ~src;
                  end
                  OP_INC:
                  begin
                     res = src + 8'h01;
                  end
                  OP_DECSKIP:
                  begin
                     res = src - 8'h01;
                     upd_z = 1'b0;
                     skip = (res == 8'h00);
                  end
                  OP_RRC:
                  begin
                     res = {s_r.carry, src[7:1]};
                     upd_z = 1'b0;
                     upd_c = 1'b1;
                     new_c = src[0];
                  end
                  OP_RLC:
                  begin
                     res = {src[6:0], s_r.carry};
                     upd_z = 1'b0;
                     upd_c = 1'b1;
                     new_c = src[7];
                  end
                  OP_SWAP:
                  begin
                     res = {src[3:0], src[7:4]};
                     upd_z = 1'b0;
                  end
                  OP_INCSKIP:
                  begin
                     res = src + 8'h01;
                     upd_z = 1'b0;
                     skip = (res == 8'h00);
                  end
               endcase
            end
            CLASS_BIT:
            begin
               if (!op[3])
               begin
                  res = src;
                  res[bsel] = op[2];
                  wr_res = 1'b1;
                  upd_z = 1'b0;
               end
               else
               begin
                  skip = (src[bsel] == op[2]);
               end
            end
            CLASS_JUMP:
            begin
               s_nxt.pc_load = 1'b1;
               s_nxt.pc_target = instr_word[10:0];
               s_nxt.push = !op[3];
            end
            CLASS_LIT:
            begin
               wr_res = 1'b1;
               upd_z = 1'b1;
               if (op[3:2] == 2'b00)
               begin
                  res = lit;
                  upd_z = 1'b0;
               end
               else if (op[3:2] == 2'b01)
               begin
                  res = lit;
                  upd_z = 1'b0;
                  s_nxt.pop = 1'b1;
                  s_nxt.pc_load = 1'b1;
               end
               else if (op[3:2] == 2'b11)
               begin
                  upd_c = 1'b1;
                  upd_dc = 1'b1;
                  if (op[1])
                  begin
                     sum = add8(lit, s_r.acc, 1'b0);
                  end
                  else
                  begin
                     sum = add8(lit, ~s_r.acc, 1'b1);
                  end
                  res = sum[7:0];
                  new_c = sum[9];
               end
               else if (op == OP_LIT_IOR)
               begin
                  res = s_r.acc | lit;
               end
               else if (op == OP_LIT_AND)
               begin
                  res = s_r.acc & lit;
               end
               else if (op == OP_LIT_XOR)
               begin
                  res = s_r.acc ^ lit;
               end
               else
               begin
                  wr_res = 1'b0;
                  upd_z = 1'b0;
               end
            end
         endcase

         // literal results always land in the accumulator
         if (wr_res)
         begin
            if (iclass != CLASS_LIT && (dest || iclass == CLASS_BIT))
            begin
               s_nxt.file_wr_en = 1'b1;
               s_nxt.file_addr = faddr;
               s_nxt.file_wr_data = res;
               s_nxt.psc_clr = (faddr == TIMER_ZERO_ADDR) && s_r.psa_timer;
            end
            else
            begin
               s_nxt.acc = res;
            end
         end
         if (upd_z)
         begin
            s_nxt.zero = (res == 8'h00);
         end
         if (upd_c)
         begin
            s_nxt.carry = new_c;
         end
         if (upd_dc)
         begin
            s_nxt.digit_carry_flag = sum[8];
         end
         if (skip || s_nxt.pc_load)
         begin
            s_nxt.phase = ST_FLUSH;
         end
      end

      // ---------------------------------------------------------------
      // register port
      // ---------------------------------------------------------------
      if (reg_wr && reg_addr == REG_CTRL)
      begin
         s_nxt.psa_timer = reg_wdata[CTRL_PSA_POS];
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            REG_CTRL: s_nxt.rdata = {7'h00, s_r.psa_timer};
            REG_ACC: s_nxt.rdata = s_r.acc;
            REG_STATUS: s_nxt.rdata = {3'h0, status_flags};
            default: s_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r <= '0;
         s_r.phase <= ST_EXEC;
         s_r.acc <= RST_ACC;
         s_r.timeout_status_bit <= RST_TO;
         s_r.powerdown_status_bit <= RST_POWERDOWN;
         s_r.psa_timer <= RST_PSA;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign instr_ready = (s_r.phase == ST_EXEC);
   assign nop_cycle = (s_r.phase == ST_FLUSH);
   assign reg_rdata = s_r.rdata;
   assign file_addr = s_r.file_addr;
   assign file_wr_en = s_r.file_wr_en;
   assign file_wr_data = s_r.file_wr_data;
   assign pc_load = s_r.pc_load;
   assign pc_target = s_r.pc_target;
   assign stack_push = s_r.push;
   assign stack_pop = s_r.pop;
   assign int_enable_set = s_r.gie_set;
   assign prescaler_clear = s_r.psc_clr;
   assign watchdog_clear = s_r.wdt_clr;
   assign sleep_enter = s_r.sleep;
   assign acc_value = s_r.acc;
   assign status_flags[ST_C_POS] = s_r.carry;
   assign status_flags[ST_DC_POS] = s_r.digit_carry_flag;
   assign status_flags[ST_Z_POS] = s_r.zero;
   assign status_flags[ST_POWERDOWN_POS] = s_r.powerdown_status_bit;
   assign status_flags[ST_TO_POS] = s_r.timeout_status_bit;

endmodule

//--- tb/risc14_instruction_decoder_assertions.sv
// Purpose: port-level checks for the instruction decoder
// Assumes: bound to the decoder top, one clock domain
// Notes: effects land one cycle after the word is taken
`timescale 1ns/1ps
module risc14_decoder_checker
   import risc14_pkg::*;
(
   input logic sys_clk,
   input logic rst_n,
   input logic instr_valid,
   input logic [13:0] instr_word,
   input logic instr_ready,
   input logic [7:0] acc_value,
   input logic [4:0] status_flags,
   input logic file_wr_en,
   input logic [6:0] file_addr,
   input logic pc_load,
   input logic [10:0] pc_target,
   input logic stack_push,
   input logic stack_pop,
   input logic nop_cycle,
   input logic prescaler_clear,
   input logic sleep_enter
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic tk;
   assign tk = instr_valid && instr_ready;
   // ------
   // assertions
   // ------
   a_flush_after_load: assert property (pc_load |-> nop_cycle && !instr_ready)
      else $error("pc load without flush");
   a_single_flush: assert property (nop_cycle |=> !nop_cycle)
      else $error("flush longer than one cycle");
   a_literal_return: assert property (tk && instr_word[13:10] == 4'b1101
      |=> stack_pop && pc_load && acc_value == $past(instr_word[7:0]))
      else $error("return with literal wrong");
   a_literal_and: assert property (tk && instr_word[13:8] == {CLASS_LIT, OP_LIT_AND}
      |=> acc_value == ($past(acc_value) & $past(instr_word[7:0]))
      && status_flags[ST_Z_POS] == (acc_value == 8'h00))
      else $error("literal and wrong");
   a_timer_prescale: assert property (prescaler_clear
      |-> file_wr_en && file_addr == TIMER_ZERO_ADDR)
      else $error("prescaler clear without timer write");
   a_standby_flags: assert property (sleep_enter
      |-> status_flags[ST_TO_POS] && !status_flags[ST_POWERDOWN_POS] && !nop_cycle)
      else $error("standby flags wrong");
   a_bit_no_flags: assert property (tk && instr_word[13:12] == CLASS_BIT
      |=> $stable(status_flags) && !pc_load)
      else $error("bit op touched flags");
   a_rotate_carry: assert property (tk && instr_word[13:9] == {CLASS_BYTE, 3'b110}
      |=> status_flags[4:1] == $past(status_flags[4:1]))
      else $error("rotate touched other flags");
   a_jump_target: assert property (tk && instr_word[13:12] == CLASS_JUMP
      |=> pc_load && pc_target == $past(instr_word[10:0])
      && stack_push == !$past(instr_word[11]))
      else $error("jump or call wrong");
   a_dest_acc: assert property (tk && instr_word[13:12] == CLASS_BYTE
      && instr_word[11:8] != OP_MISC && !instr_word[7] |=> !file_wr_en)
      else $error("file written with d clear");
   cover property (tk ##1 nop_cycle && !pc_load);
   cover property (sleep_enter);
   cover property (prescaler_clear);
endmodule

bind risc14_instruction_decoder risc14_decoder_checker checker_inst (
   .sys_clk, .rst_n, .instr_valid, .instr_word, .instr_ready, .acc_value,
   .status_flags, .file_wr_en, .file_addr, .pc_load, .pc_target, .stack_push,
   .stack_pop, .nop_cycle, .prescaler_clear, .sleep_enter);

//--- tb/tb_risc14_instruction_decoder.sv
// Purpose: self-checking bench for the instruction decoder
// Assumes: fetch side drops a word offered in a flush cycle
// Notes: model keeps acc, flags, psa and a file image
`timescale 1ns/1ps
module tb_risc14_instruction_decoder
   import risc14_pkg::*;
;
   logic sys_clk, rst_n, instr_valid, file_is_io, reg_wr, reg_rd, instr_ready;
   logic file_wr_en, pc_load, stack_push, stack_pop, nop_cycle, int_enable_set;
   logic prescaler_clear, watchdog_clear, sleep_enter, m_psa, poke;
   logic [13:0] instr_word;
   logic [10:0] pc_target;
   logic [7:0] pin_rd_data, file_rd_data, reg_wdata, reg_rdata;
   logic [7:0] file_wr_data, acc_value, m_acc;
   logic [7:0] em [128];
   logic [6:0] file_addr;
   logic [4:0] status_flags, m_fl;
   logic [3:0] reg_addr;
   logic [13:0] spec [18] = '{14'h0b81, 14'h0f82, 14'h0b81, WORD_RETURN, WORD_INT_RETURN,
      WORD_WDT_CLEAR, WORD_SLEEP, 14'h3455, 14'h2123, 14'h3eff, 14'h3c00, 14'h3b00,
      14'h3900, 14'h3a00, 14'h3800, 14'h3000, 14'h0100, 14'h0080};
   int mismatches, total_checks;

   assign file_rd_data = em[instr_word[6:0]];

   risc14_instruction_decoder risc14_instruction_decoder_inst (
      .sys_clk, .rst_n, .instr_valid, .instr_word, .file_rd_data, .pin_rd_data,
      .file_is_io, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_ready,
      .file_addr, .file_wr_en, .file_wr_data, .pc_load, .pc_target, .stack_push,
      .stack_pop, .nop_cycle, .int_enable_set, .prescaler_clear, .watchdog_clear,
      .sleep_enter, .acc_value, .status_flags);

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // ------
   // helpers
   // ------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   function automatic logic [9:0] alu(input logic [7:0] x, input logic [7:0] y,
      input logic sb);
      logic [8:0] t;
      logic [4:0] h;
      t = sb ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
      h = sb ? {1'b0, x[3:0]} - {1'b0, y[3:0]} : {1'b0, x[3:0]} + {1'b0, y[3:0]};
      return {t[8] ^ sb, h[4] ^ sb, t[7:0]};
   endfunction

   task automatic rwr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rrd(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(32'(reg_rdata), 32'(e));
   endtask

   task automatic step(input logic [13:0] w, input logic io, input logic [7:0] p);
      logic [9:0] v;
      logic [7:0] s;
      logic [6:0] a;
      logic [3:0] op;
      logic [2:0] b;
      logic wr, wa, fz, fc, sk, pl, pu, po, ie, wc, se, pc;
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      file_is_io <= io;
      pin_rd_data <= p;
      @(posedge sys_clk);
      instr_valid <= poke;
      // file image changes only once the taking edge is past
      @(negedge sys_clk);
      a = w[6:0];
      b = w[9:7];
      op = w[11:8];
      s = io ? p : em[a];
      v = {2'b00, m_acc};
      {wr, wa, fz, fc, sk, pl, pu, po, ie, wc, se} = '0;
      case (w[13:12])
         CLASS_BYTE:
         begin
            case (op)
               OP_CLEAR: v = 10'h000;
               OP_SUB: v = alu(s, m_acc, 1'b1);
               OP_IOR: v = {2'b00, s | m_acc};
               OP_AND: v = {2'b00, s & m_acc};
               OP_XOR: v = {2'b00, s ^ m_acc};
               OP_ADD: v = alu(s, m_acc, 1'b0);
               OP_MOVE: v = {2'b00, s};
               OP_COMP: v = {2'b00, ~s};
               OP_INC, OP_INCSKIP: v = {2'b00, s + 8'h01};
               OP_DEC, OP_DECSKIP: v = {2'b00, s - 8'h01};
               OP_RRC: v = {s[0], m_fl[1], m_fl[0], s[7:1]};
               OP_RLC: v = {s[7], m_fl[1], s[6:0], m_fl[0]};
               OP_SWAP: v = {2'b00, s[3:0], s[7:4]};
               default: ;
            endcase
            fz = !(op inside {OP_MISC, OP_DECSKIP, OP_RRC, OP_RLC, OP_SWAP, OP_INCSKIP});
            fc = op inside {OP_SUB, OP_ADD, OP_RRC, OP_RLC};
            sk = op inside {OP_DECSKIP, OP_INCSKIP} && v[7:0] == 8'h00;
            wr = w[7];
            wa = !w[7] && op != OP_MISC;
            if (w == WORD_RETURN || w == WORD_INT_RETURN)
               {pl, po, ie} = {2'b11, w[0]};
            if (w == WORD_WDT_CLEAR)
               {m_fl[4:3], wc} = 3'b111;
            if (w == WORD_SLEEP)
               {m_fl[4:3], se} = 3'b101;
         end
         CLASS_BIT:
         begin
            v = {2'b00, s};
            v[b] = w[10];
            wr = !w[11];
            sk = w[11] && s[b] == w[10];
         end
         CLASS_JUMP: {pl, pu} = {1'b1, !w[11]};
         default:
         begin
            case (op)
               OP_LIT_IOR: v = {2'b00, w[7:0] | m_acc};
               OP_LIT_AND: v = {2'b00, w[7:0] & m_acc};
               OP_LIT_XOR: v = {2'b00, w[7:0] ^ m_acc};
               4'hb: v = {2'b00, m_acc};
               default: v = w[11] ? alu(w[7:0], m_acc, !w[9]) : {2'b00, w[7:0]};
            endcase
            wa = 1'b1;
            fz = w[11] && op != 4'hb;
            fc = w[11:10] == 2'b11;
            {pl, po} = {2{w[11:10] == 2'b01}};
         end
      endcase
      if (fz)
         m_fl[2] = v[7:0] == 8'h00;
      if (fc)
         m_fl[1:0] = {v[8], v[9]};
      if (wa)
         m_acc = v[7:0];
      pc = wr && a == TIMER_ZERO_ADDR && m_psa;
      if (wr)
         em[a] = v[7:0];
      chk(32'({acc_value, status_flags}), 32'({m_acc, m_fl}));
      chk(32'({file_wr_en, prescaler_clear, nop_cycle}), 32'({wr, pc, pl | sk}));
      chk(32'({pc_load, stack_push, stack_pop}), 32'({pl, pu, po}));
      chk(32'({int_enable_set, watchdog_clear, sleep_enter}), 32'({ie, wc, se}));
      if (wr)
         chk(32'({file_addr, file_wr_data}), 32'({a, v[7:0]}));
      if (pl && !po)
         chk(32'(pc_target), 32'(w[10:0]));
   endtask

   // ------
   // sequence
   // ------
   initial
   begin
      rst_n = 1'b0;
      {instr_valid, file_is_io, reg_wr, reg_rd, poke} = '0;
      instr_word = 14'h0000;
      pin_rd_data = 8'h00;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      mismatches = 0;
      total_checks = 0;
      void'($urandom(32'h3ebb));
      foreach (em[i])
         em[i] = 8'($urandom);
      m_acc = RST_ACC;
      m_fl = {RST_TO, RST_POWERDOWN, 3'b000};
      m_psa = RST_PSA;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rrd(REG_STATUS, 8'h18);
      rrd(REG_CTRL, 8'h01);
      rwr(REG_ACC, 8'h5a);
      rrd(REG_ACC, RST_ACC);
      rrd(4'hf, 8'h00);
      for (int i = 0; i < 32; i++)
         step({CLASS_BYTE, 5'(i), TIMER_ZERO_ADDR}, 1'b0, 8'h00);
      for (int i = 0; i < 32; i++)
         step({CLASS_BIT, 5'(i), 7'($urandom)}, 1'($urandom), 8'($urandom));
      rwr(REG_CTRL, 8'h00);
      m_psa = 1'b0;
      step(14'h0181, 1'b0, 8'h00);
      rwr(REG_CTRL, 8'h01);
      m_psa = 1'b1;
      step(14'h0a85, 1'b1, 8'h3c);
      em[1] = 8'h01;
      em[2] = 8'hff;
      foreach (spec[i])
         step(spec[i], 1'b0, 8'h00);
      poke = 1'b1;
      step(14'h2805, 1'b0, 8'h00);
      poke = 1'b0;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      @(negedge sys_clk);
      chk(32'({pc_load, nop_cycle}), 32'h0000_0000);
      repeat (800)
         step(14'($urandom), 1'($urandom), 8'($urandom));
      rrd(REG_STATUS, 8'(m_fl));
      rrd(REG_ACC, m_acc);
      close_out();
   end

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      close_out();
   end
endmodule
